// file: spm_pkg.sv
// Shared types and constants for the stack pull and repeat-MAC executor
package spm_pkg;

  // Opcodes accepted in the control register
  localparam logic [15:0] OP_PULL_MULTIPLE = 16'h0035;
  localparam logic [15:0] OP_PULL_MAC_STATE = 16'h27B9;
  localparam logic [15:0] OP_REPEAT_MAC = 16'h00FB;

  // Register byte offsets on the APB
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_ACC_D = 12'h008;
  localparam logic [11:0] OFF_ACC_E = 12'h00C;
  localparam logic [11:0] OFF_INDEX_X = 12'h010;
  localparam logic [11:0] OFF_INDEX_Y = 12'h014;
  localparam logic [11:0] OFF_INDEX_Z = 12'h018;
  localparam logic [11:0] OFF_BANK_EXT = 12'h01C;
  localparam logic [11:0] OFF_COND_CODE = 12'h020;
  localparam logic [11:0] OFF_STACK = 12'h024;
  localparam logic [11:0] OFF_MAC_HI = 12'h028;
  localparam logic [11:0] OFF_ACCUM_LO = 12'h02C;
  localparam logic [11:0] OFF_ACCUM_HI = 12'h030;

  // Control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OPND_LSB = 16;

  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_ILLEGAL = 1;
  localparam int STAT_CYC_LSB = 16;

  // Pull mask layout: bit 7 is reserved and never acted on
  localparam logic [7:0] PULL_MASK_USED = 8'h7F;
  localparam int MASK_COND = 0;
  localparam int MASK_BANK = 1;
  localparam int MASK_INDEX_Z = 2;
  localparam int MASK_INDEX_Y = 3;
  localparam int MASK_INDEX_X = 4;
  localparam int MASK_E = 5;
  localparam int MASK_D = 6;

  // MAC state words on the stack, pulled in index order
  localparam logic [7:0] MAC_WORDS = 8'h1F;
  localparam int MW_H = 0;
  localparam int MW_I = 1;
  localparam int MW_ACC_TOP = 2;
  localparam int MW_ACC_MID = 3;
  localparam int MW_ACC_LOW = 4;

  // Timing counts in clock cycles, and the stack address step per pulled word
  localparam logic [3:0] PREP_CYCLES = 4'h4;
  localparam logic [3:0] TAIL_CYCLES = 4'h2;
  localparam logic [3:0] PASS_WAIT = 4'h8;
  localparam logic [15:0] STACK_STEP = 16'h0002;

  // Width of the accumulator
  localparam int ACC_W = 36;

  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [ACC_W-1:0] RST_ACC = 36'h0_0000_0000;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } spm_apb_req_s;

  // APB answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } spm_apb_rsp_s;

  // Stack memory read port
  typedef struct packed {
    logic rd;
    logic [19:0] addr;
  } spm_mem_req_s;

  // Programmer-visible core registers
  typedef struct packed {
    logic [15:0] acc_d;
    logic [15:0] acc_e;
    logic [15:0] index_x;
    logic [15:0] index_y;
    logic [15:0] index_z;
    logic [15:0] bank_ext;
    logic [15:0] condition_code_reg;
    logic [3:0] stack_extension;
    logic [15:0] stack_pointer;
    logic [15:0] mac_mult_h;
    logic [15:0] mac_mult_i;
    logic [ACC_W-1:0] mac_accum;
  } spm_core_regs_s;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_PREP,
    ST_ADVANCE,
    ST_LOAD,
    ST_TAIL,
    ST_RM_MAC,
    ST_RM_FETCH_H,
    ST_RM_FETCH_I,
    ST_RM_DEC,
    ST_RM_WAIT
  } spm_state_e;

  // Which instruction is running
  typedef enum logic [1:0] {
    MD_PULL_MULTIPLE,
    MD_PULL_MAC,
    MD_REPEAT_MAC
  } spm_mode_e;

endpackage

// file: spm_mac_unit.sv
// Signed 16-bit fractional multiply added to the accumulator
`timescale 1ns/1ns
module spm_mac_unit #(
  parameter int ACC_W = 36
) (
  // Operands
  input wire logic [15:0] mult_h,
  input wire logic [15:0] mult_i,
  // Accumulator in and out
  input wire logic [ACC_W-1:0] accum_in,
  output logic [ACC_W-1:0] accum_out
);

  // Need room for the doubled 32-bit product plus sign
  if (ACC_W < 33) begin : g_acc_w_check
    $error("spm_mac_unit: ACC_W must be at least 33");
  end

  logic signed [31:0] prod; // Raw signed product
  logic [ACC_W-1:0] frac; // Product aligned as a fraction

  // Fraction alignment: one left shift drops the duplicate sign bit
  always_comb begin
    prod = $signed(mult_h) * $signed(mult_i);
    frac = ACC_W'({{(ACC_W-32){prod[31]}}, prod} << 1);
    accum_out = accum_in + frac;
  end

endmodule

// file: spm_exec.sv
// Executor for multiple pull, MAC state pull and repeating MAC
//
// Overview of operation
// [RULE1] Opcode 35 pulls registers chosen by mask
// [RULE2] Per set bit: stack plus two, load
// [RULE3] Multiple pull lasts 4+2(N+1) cycles
// [RULE4] Opcode 27B9 restores MAC state, 16 cycles
// [RULE5] Opcode FB repeats MAC until E negative
// [RULE6] Reserved mask bit 7 does nothing
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ns
module spm_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire spm_pkg::spm_apb_req_s apb_req,
  output spm_pkg::spm_apb_rsp_s apb_rsp,
  // Stack memory read port, data valid in the read cycle
  output spm_pkg::spm_mem_req_s mem_req,
  input wire logic [15:0] mem_rdata,
  // Status
  output logic busy
);

  // Complete module state
  typedef struct packed {
    spm_pkg::spm_state_e fsm;
    spm_pkg::spm_mode_e mode;
    logic [3:0] cnt;
    logic [7:0] pend;
    logic [7:0] opnd;
    logic [15:0] cyc;
    logic [15:0] last_cyc;
    logic illegal;
    logic [19:0] mem_addr;
    logic [31:0] prdata;
    logic pslverr;
    spm_pkg::spm_core_regs_s r;
  } spm_state_s;

  spm_state_s s_q; // Registered state
  spm_state_s s_d; // Next state
  logic [spm_pkg::ACC_W-1:0] acc_sum; // Accumulator after one product

  // Accumulate with the current multiplier operands
  spm_mac_unit #(
    .ACC_W(spm_pkg::ACC_W)
  ) u_mac (
    .mult_h(s_q.r.mac_mult_h),
    .mult_i(s_q.r.mac_mult_i),
    .accum_in(s_q.r.mac_accum),
    .accum_out(acc_sum)
  );

  // Lowest pending bit, scanned high to low so the lowest wins
  function automatic logic [2:0] first_bit(input logic [7:0] m);
    logic [2:0] idx;
    idx = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (m[k]) begin
        idx = 3'(k);
      end
    end
    return idx;
  endfunction

  // Sign extension of a 4-bit index step
  function automatic logic [15:0] step4(input logic [3:0] v);
    return {{12{v[3]}}, v};
  endfunction

  // Outputs
  assign busy = (s_q.fsm != spm_pkg::ST_IDLE);
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = s_q.pslverr;
  assign apb_rsp.prdata = s_q.prdata;
  assign mem_req.addr = s_q.mem_addr;
  assign mem_req.rd = (s_q.fsm == spm_pkg::ST_LOAD) ||
                      (s_q.fsm == spm_pkg::ST_RM_FETCH_H) ||
                      (s_q.fsm == spm_pkg::ST_RM_FETCH_I);

  // Next-state logic: bus slave and instruction sequencer
  always_comb begin
    logic setup;
    logic access;
    logic [2:0] sel;
    logic [7:0] rest;
    logic [19:0] stk;
    setup = apb_req.psel && !apb_req.penable;
    access = apb_req.psel && apb_req.penable;
    sel = first_bit(s_q.pend);
    rest = s_q.pend & ~(8'h01 << sel);
    stk = {s_q.r.stack_extension, s_q.r.stack_pointer};
    s_d = s_q;

    // Read data captured in the setup cycle, shown in the access cycle
    if (setup) begin
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h0000_0000;
      case (apb_req.paddr)
        spm_pkg::OFF_CTRL: begin
          s_d.prdata = {s_q.opnd, 8'h00, 16'h0000};
        end
        spm_pkg::OFF_STATUS: begin
          s_d.prdata[spm_pkg::STAT_BUSY] = busy;
          s_d.prdata[spm_pkg::STAT_ILLEGAL] = s_q.illegal;
          s_d.prdata[spm_pkg::STAT_CYC_LSB +: 16] = s_q.last_cyc;
        end
        spm_pkg::OFF_ACC_D: s_d.prdata[15:0] = s_q.r.acc_d;
        spm_pkg::OFF_ACC_E: s_d.prdata[15:0] = s_q.r.acc_e;
        spm_pkg::OFF_INDEX_X: s_d.prdata[15:0] = s_q.r.index_x;
        spm_pkg::OFF_INDEX_Y: s_d.prdata[15:0] = s_q.r.index_y;
        spm_pkg::OFF_INDEX_Z: s_d.prdata[15:0] = s_q.r.index_z;
        spm_pkg::OFF_BANK_EXT: s_d.prdata[15:0] = s_q.r.bank_ext;
        spm_pkg::OFF_COND_CODE: s_d.prdata[15:0] = s_q.r.condition_code_reg;
        spm_pkg::OFF_STACK: s_d.prdata[19:0] = stk;
        spm_pkg::OFF_MAC_HI: begin
          s_d.prdata = {s_q.r.mac_mult_h, s_q.r.mac_mult_i};
        end
        spm_pkg::OFF_ACCUM_LO: s_d.prdata = s_q.r.mac_accum[31:0];
        spm_pkg::OFF_ACCUM_HI: begin
          s_d.prdata[3:0] = s_q.r.mac_accum[spm_pkg::ACC_W-1:32];
        end
        // Unmapped: reads zero and flags an error
        default: s_d.pslverr = 1'b1;
      endcase
    end

    // Writes land at the access edge; bus writes are ignored while busy
    if (access && apb_req.pwrite && !busy) begin
      case (apb_req.paddr)
        spm_pkg::OFF_CTRL: begin
          s_d.opnd = apb_req.pwdata[spm_pkg::CTRL_OPND_LSB +: 8];
          s_d.cyc = 16'h0000;
          s_d.cnt = spm_pkg::PREP_CYCLES - 4'h1;
          s_d.illegal = 1'b0;
          s_d.fsm = spm_pkg::ST_PREP;
          case (apb_req.pwdata[spm_pkg::CTRL_OP_LSB +: 16])
            spm_pkg::OP_PULL_MULTIPLE: begin
              s_d.mode = spm_pkg::MD_PULL_MULTIPLE; // [RULE1]
              // Bit 7 masked off: no load, no step, no cycles
              s_d.pend = apb_req.pwdata[spm_pkg::CTRL_OPND_LSB +: 8] &
                         spm_pkg::PULL_MASK_USED; // [RULE6]
            end
            spm_pkg::OP_PULL_MAC_STATE: begin
              s_d.mode = spm_pkg::MD_PULL_MAC;
              s_d.pend = spm_pkg::MAC_WORDS; // [RULE4]
            end
            spm_pkg::OP_REPEAT_MAC: begin
              s_d.mode = spm_pkg::MD_REPEAT_MAC;
              s_d.pend = 8'h00;
            end
            // Unknown opcode: nothing runs
            default: begin
              s_d.illegal = 1'b1;
              s_d.fsm = spm_pkg::ST_IDLE;
            end
          endcase
        end
        spm_pkg::OFF_ACC_D: s_d.r.acc_d = apb_req.pwdata[15:0];
        spm_pkg::OFF_ACC_E: s_d.r.acc_e = apb_req.pwdata[15:0];
        spm_pkg::OFF_INDEX_X: s_d.r.index_x = apb_req.pwdata[15:0];
        spm_pkg::OFF_INDEX_Y: s_d.r.index_y = apb_req.pwdata[15:0];
        spm_pkg::OFF_INDEX_Z: s_d.r.index_z = apb_req.pwdata[15:0];
        spm_pkg::OFF_BANK_EXT: s_d.r.bank_ext = apb_req.pwdata[15:0];
        spm_pkg::OFF_COND_CODE: begin
          s_d.r.condition_code_reg = apb_req.pwdata[15:0];
        end
        spm_pkg::OFF_STACK: begin
          s_d.r.stack_extension = apb_req.pwdata[19:16];
          s_d.r.stack_pointer = apb_req.pwdata[15:0];
        end
        spm_pkg::OFF_MAC_HI: begin
          s_d.r.mac_mult_h = apb_req.pwdata[31:16];
          s_d.r.mac_mult_i = apb_req.pwdata[15:0];
        end
        spm_pkg::OFF_ACCUM_LO: s_d.r.mac_accum[31:0] = apb_req.pwdata;
        spm_pkg::OFF_ACCUM_HI: begin
          s_d.r.mac_accum[spm_pkg::ACC_W-1:32] = apb_req.pwdata[3:0];
        end
        // Read-only or unmapped: no effect
        default: ;
      endcase
    end

    // Cycle count of the running instruction
    if (busy) begin
      s_d.cyc = s_q.cyc + 16'h0001;
    end

    // Instruction sequencer
    case (s_q.fsm)
      // Idle: waiting for a control write
      spm_pkg::ST_IDLE: ;
      // Fixed opening cycles, then work or the closing cycles
      spm_pkg::ST_PREP: begin
        s_d.cnt = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h0) begin
          if (s_q.mode == spm_pkg::MD_REPEAT_MAC) begin
            // Check before each pass: negative E ends the loop
            if (s_q.r.acc_e[15]) begin
              s_d.fsm = spm_pkg::ST_TAIL;
              s_d.cnt = spm_pkg::TAIL_CYCLES - 4'h1;
            end else begin
              s_d.fsm = spm_pkg::ST_RM_MAC; // [RULE5]
            end
          end else if (s_q.pend != 8'h00) begin
            s_d.fsm = spm_pkg::ST_ADVANCE;
          end else begin
            s_d.fsm = spm_pkg::ST_TAIL; // [RULE3]
            s_d.cnt = spm_pkg::TAIL_CYCLES - 4'h1;
          end
        end
      end
      // Step the stack up by one word and aim the read there
      spm_pkg::ST_ADVANCE: begin
        {s_d.r.stack_extension, s_d.r.stack_pointer} =
          stk + 20'(spm_pkg::STACK_STEP); // [RULE2]
        s_d.mem_addr = stk + 20'(spm_pkg::STACK_STEP);
        s_d.fsm = spm_pkg::ST_LOAD;
      end
      // Load the selected register from the stack word
      spm_pkg::ST_LOAD: begin
        s_d.pend = rest;
        if (s_q.mode == spm_pkg::MD_PULL_MULTIPLE) begin
          case (int'(sel)) // [RULE1] [RULE2]
            spm_pkg::MASK_COND: begin
              // Only the upper condition bits are restored
              s_d.r.condition_code_reg[15:4] = mem_rdata[15:4];
            end
            spm_pkg::MASK_BANK: s_d.r.bank_ext = mem_rdata;
            spm_pkg::MASK_INDEX_Z: s_d.r.index_z = mem_rdata;
            spm_pkg::MASK_INDEX_Y: s_d.r.index_y = mem_rdata;
            spm_pkg::MASK_INDEX_X: s_d.r.index_x = mem_rdata;
            spm_pkg::MASK_E: s_d.r.acc_e = mem_rdata;
            spm_pkg::MASK_D: s_d.r.acc_d = mem_rdata;
            default: ;
          endcase
        end else begin
          case (int'(sel)) // [RULE4]
            spm_pkg::MW_H: s_d.r.mac_mult_h = mem_rdata;
            spm_pkg::MW_I: s_d.r.mac_mult_i = mem_rdata;
            spm_pkg::MW_ACC_TOP: begin
              s_d.r.mac_accum[spm_pkg::ACC_W-1:32] = mem_rdata[3:0];
            end
            spm_pkg::MW_ACC_MID: s_d.r.mac_accum[31:16] = mem_rdata;
            spm_pkg::MW_ACC_LOW: s_d.r.mac_accum[15:0] = mem_rdata;
            default: ;
          endcase
        end
        if (rest != 8'h00) begin
          s_d.fsm = spm_pkg::ST_ADVANCE;
        end else begin
          s_d.fsm = spm_pkg::ST_TAIL; // [RULE3]
          s_d.cnt = spm_pkg::TAIL_CYCLES - 4'h1;
        end
      end
      // Closing cycles; record the total at the last one
      spm_pkg::ST_TAIL: begin
        s_d.cnt = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h0) begin
          s_d.fsm = spm_pkg::ST_IDLE;
          s_d.last_cyc = s_q.cyc + 16'h0001;
        end
      end
      // Pass step 1: accumulate the current product
      spm_pkg::ST_RM_MAC: begin
        s_d.r.mac_accum = acc_sum; // [RULE5]
        s_d.mem_addr = {s_q.r.bank_ext[11:8], s_q.r.index_x};
        s_d.fsm = spm_pkg::ST_RM_FETCH_H;
      end
      // Pass step 2: new H from the X operand, advance X
      spm_pkg::ST_RM_FETCH_H: begin
        s_d.r.mac_mult_h = mem_rdata;
        s_d.r.index_x = s_q.r.index_x + step4(s_q.opnd[7:4]);
        s_d.mem_addr = {s_q.r.bank_ext[7:4], s_q.r.index_y};
        s_d.fsm = spm_pkg::ST_RM_FETCH_I;
      end
      // Pass step 3: new I from the Y operand, advance Y
      spm_pkg::ST_RM_FETCH_I: begin
        s_d.r.mac_mult_i = mem_rdata;
        s_d.r.index_y = s_q.r.index_y + step4(s_q.opnd[3:0]);
        s_d.fsm = spm_pkg::ST_RM_DEC;
      end
      // Pass step 4: count the pass off
      spm_pkg::ST_RM_DEC: begin
        s_d.r.acc_e = s_q.r.acc_e - 16'h0001; // [RULE5]
        s_d.cnt = spm_pkg::PASS_WAIT - 4'h1;
        s_d.fsm = spm_pkg::ST_RM_WAIT;
      end
      // Pad the pass to twelve cycles, then test E again
      spm_pkg::ST_RM_WAIT: begin
        s_d.cnt = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h0) begin
          if (s_q.r.acc_e[15]) begin
            s_d.fsm = spm_pkg::ST_TAIL; // [RULE5]
            s_d.cnt = spm_pkg::TAIL_CYCLES - 4'h1;
          end else begin
            s_d.fsm = spm_pkg::ST_RM_MAC;
          end
        end
      end
      // Unreachable codes return to idle
      default: s_d.fsm = spm_pkg::ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// file: spm_stack_mem.sv
// Behavioural stack memory answering the executor's read port
`timescale 1ns/1ns
module spm_stack_mem (
  // Clock
  input wire logic clk,
  // Read port from the executor
  input wire spm_pkg::spm_mem_req_s mem_req,
  output logic [15:0] mem_rdata
);
  // Last word handed out, kept to scramble the idle bus
  logic [15:0] last_q = 16'h0000;

  // Data is a fixed function of the address so the bench can predict it;
  // when idle the bus shows the inverse so a late sample cannot pass
  assign mem_rdata = mem_req.rd ? (mem_req.addr[15:0] ^ 16'h5A5A) : ~last_q;

  // Remember what was driven during a read
  always_ff @(posedge clk) begin
    if (mem_req.rd) begin
      last_q <= mem_rdata;
    end
  end
endmodule

// file: spm_exec_props.sv
// Concurrent checks on the executor's ports
`timescale 1ns/1ns
module spm_exec_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus and memory ports
  input wire spm_pkg::spm_apb_req_s apb_req,
  input wire spm_pkg::spm_apb_rsp_s apb_rsp,
  input wire spm_pkg::spm_mem_req_s mem_req,
  input wire logic [15:0] mem_rdata,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Accepted instruction write and its decode
  logic ctrl_wr;
  logic [15:0] op;
  logic legal;
  assign op = apb_req.pwdata[15:0];
  assign ctrl_wr = apb_req.psel & apb_req.penable & apb_req.pwrite &
    (apb_req.paddr == spm_pkg::OFF_CTRL) & !busy;
  assign legal = (op == spm_pkg::OP_PULL_MULTIPLE) ||
    (op == spm_pkg::OP_PULL_MAC_STATE) || (op == spm_pkg::OP_REPEAT_MAC);

  // Helper counters: busy length, reads, last read address
  logic [15:0] run_q;
  logic [7:0] rdn_q;
  logic [3:0] npull_q;
  logic [1:0] mode_q;
  logic [19:0] last_q;
  logic seen_q;

  // Mask bits 0..6 only; bit 7 is reserved
  function automatic logic [3:0] ones7(input logic [7:0] m);
    logic [3:0] c;
    c = 4'h0;
    for (int b = 0; b < 7; b++) c = c + {3'h0, m[b]};
    return c;
  endfunction

  // Count per instruction, restarting at each accepted write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_q <= 16'h0000;
      rdn_q <= 8'h00;
      npull_q <= 4'h0;
      mode_q <= 2'h3;
      last_q <= 20'h00000;
      seen_q <= 1'b0;
    end else if (ctrl_wr) begin
      run_q <= 16'h0000;
      rdn_q <= 8'h00;
      seen_q <= 1'b0;
      npull_q <= ones7(apb_req.pwdata[23:16]);
      mode_q <= (op == spm_pkg::OP_PULL_MULTIPLE) ? 2'h0 :
        (op == spm_pkg::OP_PULL_MAC_STATE) ? 2'h1 :
        (op == spm_pkg::OP_REPEAT_MAC) ? 2'h2 : 2'h3;
    end else begin
      if (busy) run_q <= run_q + 16'h0001;
      if (mem_req.rd) begin
        rdn_q <= rdn_q + 8'h01;
        last_q <= mem_req.addr;
        seen_q <= 1'b1;
      end
    end
  end

  sequence s_start_legal;
    ctrl_wr && legal;
  endsequence
  sequence s_done;
    $fell(busy);
  endsequence

  chk_busy_starts: assert property (s_start_legal |=> busy)
    else $error("busy did not rise after an instruction write");
  chk_illegal_idle: assert property (ctrl_wr && !legal |=> !busy [*2])
    else $error("unknown opcode started the sequencer");
  chk_pull_cycles: assert property (s_done and mode_q == 2'h0 |->
    run_q == 16'(4 + 2 * (int'(npull_q) + 1)))
    else $error("multiple pull length wrong");
  chk_pull_reads: assert property (s_done and mode_q == 2'h0 |->
    rdn_q == {4'h0, npull_q})
    else $error("multiple pull read count wrong");
  chk_pull_step: assert property (mem_req.rd && mode_q == 2'h0 && seen_q |->
    mem_req.addr == last_q + 20'h00002)
    else $error("stack did not advance by two");
  chk_mac_cycles: assert property (s_done and mode_q == 2'h1 |->
    run_q == 16'd16)
    else $error("mac state pull length wrong");
  chk_repeat_cycles: assert property (s_done and mode_q == 2'h2 |->
    run_q >= 16'd6 && (run_q - 16'd6) % 16'd12 == 16'd0)
    else $error("repeat mac length wrong");
  chk_repeat_reads: assert property (s_done and mode_q == 2'h2 |->
    {8'h00, rdn_q} * 16'd6 == run_q - 16'd6)
    else $error("repeat mac fetch count wrong");
  chk_read_busy: assert property (mem_req.rd |-> busy)
    else $error("memory read while idle");
endmodule

bind spm_exec spm_exec_props chk_u (.clk(clk), .rstn(rstn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .mem_req(mem_req),
  .mem_rdata(mem_rdata), .busy(busy));

// file: testbench.sv
// Self-checking bench for the pull and repeat-MAC executor
`timescale 1ns/1ns
module testbench;
  // Design connections
  logic clk;
  logic rstn;
  spm_pkg::spm_apb_req_s apb_req;
  spm_pkg::spm_apb_rsp_s apb_rsp;
  spm_pkg::spm_mem_req_s mem_req;
  logic [15:0] mem_rdata;
  logic busy;
  // Scoreboard and reference state
  int mismatches;
  int samples_checked;
  logic [31:0] rdv;
  logic err;
  logic [19:0] stk;
  logic [15:0] h, i;
  logic [35:0] acc;
  logic [11:0] offs [7];

  spm_exec dut_u (.clk(clk), .rstn(rstn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .busy(busy));
  spm_stack_mem mem_u (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Word the memory model returns for an address
  function automatic logic [15:0] md(input logic [19:0] a);
    return a[15:0] ^ 16'h5A5A;
  endfunction

  task automatic final_report;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [35:0] ex,
                     input logic [35:0] got);
    samples_checked++;
    if (got !== ex) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // One APB transfer: setup, then access held until pready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 100);
    // A wait that ran out counts as a mismatch
    if (apb_rsp.pready !== 1'b1) begin
      chk("pready", 36'h1, {35'h0, apb_rsp.pready});
    end
    rdv = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  // Read and compare under a mask
  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [31:0] ex, input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, {4'h0, ex & m}, {4'h0, rdv & m});
  endtask

  // Issue an instruction, wait for idle, check the cycle figure
  task automatic run(input logic [15:0] op, input logic [7:0] opnd,
                     input logic [15:0] cyc);
    int n;
    n = 0;
    apb(1'b1, spm_pkg::OFF_CTRL, {8'h00, opnd, op});
    do begin
      @(negedge clk);
      n++;
    end while (busy !== 1'b0 && n < 2000);
    if (busy !== 1'b0) begin
      chk("busy", 36'h0, {35'h0, busy});
    end
    rdchk("status", spm_pkg::OFF_STATUS, {cyc, 16'h0000}, 32'hFFFF_0003);
  endtask

  // Multiple pull: each set bit 0..6 reads the next word up the stack
  task automatic pull(input logic [7:0] m);
    run(spm_pkg::OP_PULL_MULTIPLE, m,
        16'(4 + 2 * ($countones(m[6:0]) + 1)));
    for (int b = 0; b < 7; b++) begin
      if (m[b]) begin
        stk = stk + 20'h00002;
        rdchk("pulled", offs[b], {16'h0000, md(stk)},
              (b == 0) ? 32'hFFFF_FFF0 : 32'hFFFF_FFFF);
      end
    end
    rdchk("stack", spm_pkg::OFF_STACK, {12'h000, stk}, '1);
  endtask

  // Repeat MAC with E=2: three passes, X steps +1 and Y steps -1
  task automatic rep_mac;
    logic [15:0] x, y;
    logic signed [31:0] pr;
    x = 16'h0100;
    y = 16'h0200;
    apb(1'b1, spm_pkg::OFF_INDEX_X, {16'h0000, x});
    apb(1'b1, spm_pkg::OFF_INDEX_Y, {16'h0000, y});
    apb(1'b1, spm_pkg::OFF_ACC_E, 32'h0000_0002);
    for (int p = 0; p < 3; p++) begin
      pr = $signed(h) * $signed(i);
      acc = acc + {{3{pr[31]}}, pr, 1'b0};
      h = md({4'h0, x});
      x = x + 16'h0001;
      i = md({4'h0, y});
      y = y - 16'h0001;
    end
    run(spm_pkg::OP_REPEAT_MAC, 8'h1F, 16'd42);
    rdchk("e", spm_pkg::OFF_ACC_E, 32'h0000_FFFF, '1);
    rdchk("x", spm_pkg::OFF_INDEX_X, {16'h0000, x}, '1);
    rdchk("y", spm_pkg::OFF_INDEX_Y, {16'h0000, y}, '1);
    rdchk("hi", spm_pkg::OFF_MAC_HI, {h, i}, '1);
    rdchk("acc lo", spm_pkg::OFF_ACCUM_LO, acc[31:0], '1);
    rdchk("acc hi", spm_pkg::OFF_ACCUM_HI, {28'h0, acc[35:32]}, '1);
    // Negative E at start: no pass at all
    apb(1'b1, spm_pkg::OFF_ACC_E, 32'h0000_8000);
    run(spm_pkg::OP_REPEAT_MAC, 8'h1F, 16'd6);
    rdchk("x idle", spm_pkg::OFF_INDEX_X, {16'h0000, x}, '1);
  endtask

  // Watchdog against a hung sequencer
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end

  // Main sequence
  initial begin
    logic [15:0] w;
    apb_req = '0;
    rstn = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    offs = '{spm_pkg::OFF_COND_CODE, spm_pkg::OFF_BANK_EXT,
      spm_pkg::OFF_INDEX_Z, spm_pkg::OFF_INDEX_Y, spm_pkg::OFF_INDEX_X,
      spm_pkg::OFF_ACC_E, spm_pkg::OFF_ACC_D};
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rdchk("status rst", spm_pkg::OFF_STATUS, 32'h0, '1);
    rdchk("stack rst", spm_pkg::OFF_STACK, 32'h0, '1);
    // Unmapped address is refused
    apb(1'b0, 12'h0FC, 32'h0);
    chk("slverr", 36'h1, {35'h0, err});
    chk("unmapped", 36'h0, {4'h0, rdv});
    // Unknown opcode: illegal flag, sequencer stays idle
    apb(1'b1, spm_pkg::OFF_CTRL, 32'h0000_1234);
    rdchk("illegal", spm_pkg::OFF_STATUS, 32'h2, 32'h3);
    stk = 20'h01000;
    apb(1'b1, spm_pkg::OFF_STACK, {12'h000, stk});
    pull(8'h01);
    pull(8'h7F);
    pull(8'h80);
    pull(8'hAA);
    // Operand of the last instruction reads back in the top byte
    rdchk("ctrl", spm_pkg::OFF_CTRL, 32'hAA00_0000, '1);
    // MAC state: H, I, then accumulator top, middle, low
    run(spm_pkg::OP_PULL_MAC_STATE, 8'h00, 16'd16);
    h = md(stk + 20'h2);
    i = md(stk + 20'h4);
    w = md(stk + 20'h6);
    acc = {w[3:0], md(stk + 20'h8), md(stk + 20'hA)};
    stk = stk + 20'hA;
    rdchk("mac hi", spm_pkg::OFF_MAC_HI, {h, i}, '1);
    rdchk("mac acc", spm_pkg::OFF_ACCUM_LO, acc[31:0], '1);
    rdchk("mac top", spm_pkg::OFF_ACCUM_HI, {28'h0, acc[35:32]}, '1);
    rdchk("mac stack", spm_pkg::OFF_STACK, {12'h000, stk}, '1);
    rep_mac();
    final_report();
  end
endmodule
